//--- src/channel_clock_divider_groups.sv
// Group 2 and group 3 channel dividers with their control registers.
// Assumes core_clk is the divider input clock and the register port
// and sync level are synchronous to it.
`timescale 1ns/100ps
`default_nettype none

// Function
// [R1] Low lasts low field plus one cycles
// [R2] High lasts high field plus one cycles
// [R3] Group 3 counts reset to zero
// [R4] Bypass passes input clock to output
// [R5] Bypass clear uses the divider
// [R6] Sync mask makes divider ignore sync
// [R7] Software sets sync mask when forcing
// [R8] Forced level is low or start level
// [R9] Force ignored in bypass; inversion stays
// [R10] Start level chooses initial output level
// [R11] Four-bit phase offset, resets to zero
// [R12] Power-down puts three outputs safe
// [R13] Direct clear feeds outputs from divider
// [R14] Direct routes VCO or CLK by source
// [R15] Duty correction active unless disabled
// [R16] Group 2 and 3 output assignment
// [R17] Group 2 counts reset to one
// [R18] Phase offset delays first edge after sync
// [R19] Period is low plus high durations
module channel_clock_divider_groups (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [chan_div_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [chan_div_pkg::DATA_W-1:0] reg_wdata,
	output logic [chan_div_pkg::DATA_W-1:0] reg_rdata,
	input wire logic sync_hold,
	input wire logic [1:0] clk_source_sel,
	input wire logic vco_level,
	input wire logic [2:0] group2_invert,
	input wire logic [2:0] group3_invert,
	output logic group2_output_a,
	output logic group2_output_b,
	output logic group2_output_c,
	output logic group3_output_a,
	output logic group3_output_b,
	output logic group3_output_c,
	output logic group2_duty_cycle_correction,
	output logic group3_duty_cycle_correction
);

	// Control registers of group 2
	chan_div_pkg::cycle_counts_t g2_cycles_r;
	chan_div_pkg::cycle_counts_t g2_cycles_nxt;
	chan_div_pkg::divider_control_t g2_divctl_r;
	chan_div_pkg::divider_control_t g2_divctl_nxt;
	chan_div_pkg::channel_control_t g2_chanctl_r;
	chan_div_pkg::channel_control_t g2_chanctl_nxt;

	// Control registers of group 3
	chan_div_pkg::cycle_counts_t g3_cycles_r;
	chan_div_pkg::cycle_counts_t g3_cycles_nxt;
	chan_div_pkg::divider_control_t g3_divctl_r;
	chan_div_pkg::divider_control_t g3_divctl_nxt;
	chan_div_pkg::channel_control_t g3_chanctl_r;
	chan_div_pkg::channel_control_t g3_chanctl_nxt;

	// Read data register
	logic [chan_div_pkg::DATA_W-1:0] rdata_r;
	logic [chan_div_pkg::DATA_W-1:0] rdata_nxt;

	// Cycle-level copy of the divider input clock
	logic in_clk_r;
	logic in_clk_nxt;

	// Duty-cycle correction enables
	logic g2_dcc_r;
	logic g2_dcc_nxt;
	logic g3_dcc_r;
	logic g3_dcc_nxt;

	// Divider hold controls and levels
	logic g2_hold;
	logic g3_hold;
	logic g2_hold_level;
	logic g3_hold_level;
	logic g2_div_level;
	logic g3_div_level;

	// Channel levels after bypass and direct routing
	logic g2_level;
	logic g3_level;
	// Registered driver levels, index 0 to 2 for outputs a to c
	wire [2:0] g2_q;
	wire [2:0] g3_q;

	// Register write decode
	always_comb
	begin
		g2_cycles_nxt = g2_cycles_r;
		g2_divctl_nxt = g2_divctl_r;
		g2_chanctl_nxt = g2_chanctl_r;
		g3_cycles_nxt = g3_cycles_r;
		g3_divctl_nxt = g3_divctl_r;
		g3_chanctl_nxt = g3_chanctl_r;
		if (reg_wr_en)
		begin
			case (reg_addr)
				chan_div_pkg::GROUP2_CYCLE_COUNTS_OFS:
				begin
					g2_cycles_nxt = reg_wdata;
				end
				chan_div_pkg::GROUP2_DIVIDER_CONTROL_OFS:
				begin
					g2_divctl_nxt = reg_wdata;
				end
				chan_div_pkg::GROUP2_CHANNEL_CONTROL_OFS:
				begin
					// Unused bits are not stored
					g2_chanctl_nxt = {5'h00, reg_wdata[2:0]};
				end
				chan_div_pkg::GROUP3_CYCLE_COUNTS_OFS:
				begin
					g3_cycles_nxt = reg_wdata;
				end
				chan_div_pkg::GROUP3_DIVIDER_CONTROL_OFS:
				begin
					g3_divctl_nxt = reg_wdata;
				end
				chan_div_pkg::GROUP3_CHANNEL_CONTROL_OFS:
				begin
					g3_chanctl_nxt = {5'h00, reg_wdata[2:0]};
				end
				default:
				begin
					// Unmapped writes are dropped
				end
			endcase
		end
	end

	// Register read mux; data appears one cycle after the read strobe
	always_comb
	begin
		rdata_nxt = rdata_r;
		if (reg_rd_en)
		begin
			case (reg_addr)
				chan_div_pkg::GROUP2_CYCLE_COUNTS_OFS:
				begin
					rdata_nxt = g2_cycles_r;
				end
				chan_div_pkg::GROUP2_DIVIDER_CONTROL_OFS:
				begin
					rdata_nxt = g2_divctl_r;
				end
				chan_div_pkg::GROUP2_CHANNEL_CONTROL_OFS:
				begin
					rdata_nxt = g2_chanctl_r;
				end
				chan_div_pkg::GROUP3_CYCLE_COUNTS_OFS:
				begin
					rdata_nxt = g3_cycles_r;
				end
				chan_div_pkg::GROUP3_DIVIDER_CONTROL_OFS:
				begin
					rdata_nxt = g3_divctl_r;
				end
				chan_div_pkg::GROUP3_CHANNEL_CONTROL_OFS:
				begin
					rdata_nxt = g3_chanctl_r;
				end
				default:
				begin
					rdata_nxt = chan_div_pkg::UNMAPPED_READ;
				end
			endcase
		end
	end

	// Control registers and their reset values
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			g2_cycles_r <= chan_div_pkg::GROUP2_CYCLES_RST; // R17
			g2_divctl_r <= chan_div_pkg::DIVIDER_CONTROL_RST; // R11 R5
			g2_chanctl_r <= chan_div_pkg::CHANNEL_CONTROL_RST;
			g3_cycles_r <= chan_div_pkg::GROUP3_CYCLES_RST; // R3
			g3_divctl_r <= chan_div_pkg::DIVIDER_CONTROL_RST; // R11 R5
			g3_chanctl_r <= chan_div_pkg::CHANNEL_CONTROL_RST;
			rdata_r <= chan_div_pkg::UNMAPPED_READ;
		end
		else
		begin
			g2_cycles_r <= g2_cycles_nxt;
			g2_divctl_r <= g2_divctl_nxt;
			g2_chanctl_r <= g2_chanctl_nxt;
			g3_cycles_r <= g3_cycles_nxt;
			g3_divctl_r <= g3_divctl_nxt;
			g3_chanctl_r <= g3_chanctl_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Input clock copy and duty-correction enables
	always_comb
	begin
		in_clk_nxt = !in_clk_r;
		g2_dcc_nxt = !g2_chanctl_r.dcc_disable; // R15
		g3_dcc_nxt = !g3_chanctl_r.dcc_disable; // R15
	end

	// Clock copy and correction registers
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			in_clk_r <= 1'b0;
			g2_dcc_r <= 1'b0;
			g3_dcc_r <= 1'b0;
		end
		else
		begin
			in_clk_r <= in_clk_nxt;
			g2_dcc_r <= g2_dcc_nxt;
			g3_dcc_r <= g3_dcc_nxt;
		end
	end

	// Divider hold: bypassed dividers stop, masked ones sit static,
	// unmasked ones follow the chip sync level
	always_comb
	begin
		g2_hold = g2_divctl_r.bypass || g2_divctl_r.sync_mask
			|| sync_hold; // R4 R6 R7
		g3_hold = g3_divctl_r.bypass || g3_divctl_r.sync_mask
			|| sync_hold; // R4 R6 R7
		// Static level when masked: low, or start level if forced
		g2_hold_level = g2_divctl_r.sync_mask ? (g2_divctl_r.force_static
			&& g2_divctl_r.start_high) : g2_divctl_r.start_high; // R8
		g3_hold_level = g3_divctl_r.sync_mask ? (g3_divctl_r.force_static
			&& g3_divctl_r.start_high) : g3_divctl_r.start_high; // R8
	end

	// Group 2 divider
	divider_core #(
		.CNT_W(5)
	) u_group2_divider (
		.core_clk(core_clk),
		.resetn(resetn),
		.hold(g2_hold),
		.hold_level(g2_hold_level),
		.cycles(g2_cycles_r), // R1 R2 R19
		.start_high(g2_divctl_r.start_high), // R10
		.phase(g2_divctl_r.phase), // R18
		.level(g2_div_level)
	);

	// Group 3 divider
	divider_core #(
		.CNT_W(5)
	) u_group3_divider (
		.core_clk(core_clk),
		.resetn(resetn),
		.hold(g3_hold),
		.hold_level(g3_hold_level),
		.cycles(g3_cycles_r),
		.start_high(g3_divctl_r.start_high),
		.phase(g3_divctl_r.phase),
		.level(g3_div_level)
	);

	// Channel source: direct route first, then bypass, else divider
	always_comb
	begin
		g2_level = g2_div_level; // R13 R5
		if (g2_chanctl_r.direct && clk_source_sel == chan_div_pkg::SRC_VCO)
		begin
			g2_level = vco_level; // R14
		end
		else if (g2_chanctl_r.direct && clk_source_sel == chan_div_pkg::SRC_CLK)
		begin
			g2_level = in_clk_r; // R14
		end
		else if (g2_divctl_r.bypass)
		begin
			g2_level = in_clk_r; // R4 R9
		end
		g3_level = g3_div_level; // R13 R5
		if (g3_chanctl_r.direct && clk_source_sel == chan_div_pkg::SRC_VCO)
		begin
			g3_level = vco_level; // R14
		end
		else if (g3_chanctl_r.direct && clk_source_sel == chan_div_pkg::SRC_CLK)
		begin
			g3_level = in_clk_r; // R14
		end
		else if (g3_divctl_r.bypass)
		begin
			g3_level = in_clk_r; // R4 R9
		end
	end

	// Three drivers per group, each with its own inversion
	for (genvar i = 0; i < 3; i++)
	begin : g_drivers
		output_driver u_g2_out (
			.core_clk(core_clk),
			.resetn(resetn),
			.level(g2_level),
			.invert(group2_invert[i]),
			.power_down(g2_chanctl_r.power_down),
			.q(g2_q[i])
		); // R16 R12
		output_driver u_g3_out (
			.core_clk(core_clk),
			.resetn(resetn),
			.level(g3_level),
			.invert(group3_invert[i]),
			.power_down(g3_chanctl_r.power_down),
			.q(g3_q[i])
		); // R16 R12
	end

	// Registered outputs
	assign reg_rdata = rdata_r;
	assign group2_output_a = g2_q[0];
	assign group2_output_b = g2_q[1];
	assign group2_output_c = g2_q[2];
	assign group3_output_a = g3_q[0];
	assign group3_output_b = g3_q[1];
	assign group3_output_c = g3_q[2];
	assign group2_duty_cycle_correction = g2_dcc_r;
	assign group3_duty_cycle_correction = g3_dcc_r;

endmodule : channel_clock_divider_groups

`default_nettype wire

//--- include/chan_div_pkg.sv
// Shared constants and types for the group 2 and group 3 channel dividers.
// Assumes a single divider input clock and an 8-bit register port.
package chan_div_pkg;

	// Register port widths
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;

	// Register offsets, group 2 then group 3
	localparam logic [9:0] GROUP2_CYCLE_COUNTS_OFS = 10'h196;
	localparam logic [9:0] GROUP2_DIVIDER_CONTROL_OFS = 10'h197;
	localparam logic [9:0] GROUP2_CHANNEL_CONTROL_OFS = 10'h198;
	localparam logic [9:0] GROUP3_CYCLE_COUNTS_OFS = 10'h199;
	localparam logic [9:0] GROUP3_DIVIDER_CONTROL_OFS = 10'h19A;
	localparam logic [9:0] GROUP3_CHANNEL_CONTROL_OFS = 10'h19B;

	// Reset values
	localparam logic [7:0] GROUP2_CYCLES_RST = 8'h11;
	localparam logic [7:0] GROUP3_CYCLES_RST = 8'h00;
	localparam logic [7:0] DIVIDER_CONTROL_RST = 8'h00;
	localparam logic [7:0] CHANNEL_CONTROL_RST = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// Field positions of the divider control register
	localparam int BYPASS_BIT = 7;
	localparam int SYNC_MASK_BIT = 6;
	localparam int FORCE_STATIC_BIT = 5;
	localparam int START_HIGH_BIT = 4;
	localparam int PHASE_LSB = 0;

	// Field positions of the channel control register
	localparam int POWER_DOWN_BIT = 2;
	localparam int DIRECT_BIT = 1;
	localparam int DCC_DISABLE_BIT = 0;

	// Field positions of the cycle count register
	localparam int LOW_LSB = 4;
	localparam int HIGH_LSB = 0;

	// Clock source select encodings
	localparam logic [1:0] SRC_CLK = 2'h0;
	localparam logic [1:0] SRC_NONE = 2'h1;
	localparam logic [1:0] SRC_VCO = 2'h2;

	// Low and high durations, each field plus one input cycle
	typedef struct packed {
		logic [3:0] low_cycles;
		logic [3:0] high_cycles;
	} cycle_counts_t;

	// Divider control layout
	typedef struct packed {
		logic bypass;
		logic sync_mask;
		logic force_static;
		logic start_high;
		logic [3:0] phase;
	} divider_control_t;

	// Channel control layout; the top bits are unused and read zero
	typedef struct packed {
		logic [4:0] unused;
		logic power_down;
		logic direct;
		logic dcc_disable;
	} channel_control_t;

	// Divider sequencer states
	typedef enum logic {
		DIV_HOLD,
		DIV_RUN
	} div_state_t;

endpackage : chan_div_pkg

//--- src/divider_core.sv
// One programmable low/high clock divider with start level and phase offset.
// Assumes its controls are stable register outputs of the same clock.
`timescale 1ns/100ps
`default_nettype none

module divider_core #(
	parameter int CNT_W = 5 // Wide enough for phase plus first duration
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic hold,
	input wire logic hold_level,
	input var chan_div_pkg::cycle_counts_t cycles,
	input wire logic start_high,
	input wire logic [3:0] phase,
	output logic level
);

	chan_div_pkg::div_state_t state_r; // Sequencer state
	chan_div_pkg::div_state_t state_nxt;
	logic [CNT_W-1:0] cnt_r; // Cycles left in the current level
	logic [CNT_W-1:0] cnt_nxt;
	logic level_r; // Divided output level
	logic level_nxt;

	// Next state: hold, then run toggling between low and high
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		level_nxt = level_r;
		case (state_r)
			chan_div_pkg::DIV_HOLD:
			begin
				level_nxt = hold_level;
				// First edge is pushed back by the phase offset
				cnt_nxt = CNT_W'(phase) + CNT_W'(start_high ? cycles.high_cycles
					: cycles.low_cycles); // R18
				if (!hold)
				begin
					state_nxt = chan_div_pkg::DIV_RUN;
					level_nxt = start_high; // R10
				end
			end
			chan_div_pkg::DIV_RUN:
			begin
				if (hold)
				begin
					state_nxt = chan_div_pkg::DIV_HOLD;
					level_nxt = hold_level;
				end
				else if (cnt_r == '0)
				begin
					// Level ends; load the other duration, field plus one cycle
					level_nxt = !level_r; // R19
					cnt_nxt = CNT_W'(level_r ? cycles.low_cycles
						: cycles.high_cycles); // R1 R2
				end
				else
				begin
					cnt_nxt = cnt_r - CNT_W'(1);
				end
			end
			default:
			begin
				state_nxt = chan_div_pkg::DIV_HOLD;
			end
		endcase
	end

	// State registers
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			state_r <= chan_div_pkg::DIV_HOLD;
			cnt_r <= '0;
			level_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			level_r <= level_nxt;
		end
	end

	assign level = level_r;

endmodule : divider_core

`default_nettype wire

//--- src/output_driver.sv
// One output driver: polarity inversion and safe power-down, registered.
// Assumes the level input is a clean same-clock signal.
`timescale 1ns/100ps
`default_nettype none

module output_driver (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic level,
	input wire logic invert,
	input wire logic power_down,
	output logic q
);

	logic q_r; // Driven level
	logic q_nxt;

	// Powered down drives a safe low; inversion applies otherwise
	always_comb
	begin
		q_nxt = power_down ? 1'b0 : (level ^ invert); // R12 R9
	end

	// Output register
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			q_r <= 1'b0;
		end
		else
		begin
			q_r <= q_nxt;
		end
	end

	assign q = q_r;

endmodule : output_driver

`default_nettype wire

//--- bench/channel_clock_divider_groups_properties.sv
// Checker for the channel dividers, bound to the top module.
// Sees only the top ports and keeps its own copy of five of the six registers, all but 0x196.
`timescale 1ns/100ps
`default_nettype none

module channel_clock_divider_groups_properties (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [chan_div_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [chan_div_pkg::DATA_W-1:0] reg_wdata,
	input wire logic [chan_div_pkg::DATA_W-1:0] reg_rdata,
	input wire logic sync_hold,
	input wire logic [1:0] clk_source_sel,
	input wire logic vco_level,
	input wire logic [2:0] group2_invert,
	input wire logic [2:0] group3_invert,
	input wire logic group2_output_a,
	input wire logic group2_output_b,
	input wire logic group2_output_c,
	input wire logic group3_output_a,
	input wire logic group3_output_b,
	input wire logic group3_output_c,
	input wire logic group2_duty_cycle_correction,
	input wire logic group3_duty_cycle_correction
);
	logic [39:0] sh_r; // Copies of 0x197, group2_channel_control, group3_divider_control, group3_channel_control, group3_cycle_counts
	logic [39:0] sh_nxt; // Next copies

	// Follow register writes
	always_comb
	begin
		sh_nxt = sh_r;
		if (reg_wr_en)
		begin
			case (reg_addr)
				10'h197: sh_nxt[7:0] = reg_wdata;
				10'h198: sh_nxt[15:8] = reg_wdata;
				10'h19A: sh_nxt[23:16] = reg_wdata;
				10'h19B: sh_nxt[31:24] = reg_wdata;
				10'h199: sh_nxt[39:32] = reg_wdata;
				default: sh_nxt = sh_r;
			endcase
		end
	end

	// All copies reset to zero
	always_ff @(posedge core_clk)
		sh_r <= resetn ? sh_nxt : 40'h0;

	default clocking dclk @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	property p_cnt3_read;
		reg_rd_en && !reg_wr_en && reg_addr == 10'h199 |=> reg_rdata == $past(sh_r[39:32]);
	endproperty
	a_cnt3_read: assert property (p_cnt3_read) else $error("group 3 counts misread");

	property p_pd2;
		sh_r[10] [*2] |-> {group2_output_c, group2_output_b, group2_output_a} == 3'h0;
	endproperty
	a_pd2: assert property (p_pd2) else $error("group 2 not powered down");

	property p_pd3;
		sh_r[26] ##1 sh_r[26] |-> !(group3_output_a || group3_output_b || group3_output_c);
	endproperty
	a_pd3: assert property (p_pd3) else $error("group 3 not powered down");

	property p_dcc3;
		$stable(sh_r[24]) [*3] |-> group3_duty_cycle_correction == !sh_r[24];
	endproperty
	a_dcc3: assert property (p_dcc3) else $error("group 3 correction flag wrong");

	property p_byp3;
		(sh_r[23] && !sh_r[26] && !sh_r[25] && $stable(group3_invert)) [*4]
			|-> group3_output_a != $past(group3_output_a);
	endproperty
	a_byp3: assert property (p_byp3) else $error("bypass output not toggling");

	property p_static3;
		(sh_r[22] && !sh_r[23] && !sh_r[25] && !sh_r[26] && $stable(sh_r[23:20])
			&& $stable(group3_invert)) [*4]
			|-> group3_output_a == ((sh_r[21] & sh_r[20]) ^ group3_invert[0]);
	endproperty
	a_static3: assert property (p_static3) else $error("static level wrong");

	property p_hold2;
		(sync_hold && sh_r[7:6] == 2'h0 && sh_r[10:9] == 2'h0 && $stable(group2_invert)) [*4]
			|-> group2_output_a == (sh_r[4] ^ group2_invert[0]);
	endproperty
	a_hold2: assert property (p_hold2) else $error("held divider not at start");

	property p_vco3;
		(sh_r[26:25] == 2'h1 && clk_source_sel == 2'h2 && $stable(vco_level)
			&& $stable(group3_invert)) [*4] |-> group3_output_a == (vco_level ^ group3_invert[0]);
	endproperty
	a_vco3: assert property (p_vco3) else $error("direct output not from source");

	c_bypass: cover property (sh_r[23] ##1 sh_r[23]);
	c_force: cover property (sh_r[22] && sh_r[21] && sh_r[20]);
	c_direct: cover property (sh_r[25] && clk_source_sel == 2'h2);
endmodule : channel_clock_divider_groups_properties

bind channel_clock_divider_groups channel_clock_divider_groups_properties u_props (
	.core_clk, .resetn, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata,
	.sync_hold, .clk_source_sel, .vco_level, .group2_invert, .group3_invert,
	.group2_output_a, .group2_output_b, .group2_output_c, .group3_output_a,
	.group3_output_b, .group3_output_c, .group2_duty_cycle_correction,
	.group3_duty_cycle_correction
);

`default_nettype wire

//--- bench/tb_top.sv
// Self-checking bench for the group 2 and group 3 channel dividers.
// Drives all inputs at the falling edge; the package is compiled first.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	logic core_clk, resetn, reg_wr_en, reg_rd_en, sync_hold, vco_level; // Scalar inputs
	logic [9:0] reg_addr; // Register offset
	logic [7:0] reg_wdata, reg_rdata; // Register data
	logic [1:0] clk_source_sel; // Direct source
	logic [2:0] group2_invert, group3_invert; // Driver inversion
	wire [2:0] og [2]; // Outputs c..a, group 2 then 3
	wire [1:0] dcc; // Correction flags, group 3 then 2
	int err_total, tests_run, seed, lo, hi, v, n; // Counters and scratch
	int mdl [6]; // Register model from 0x196 up

	channel_clock_divider_groups DUT (
		.core_clk, .resetn, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata,
		.sync_hold, .clk_source_sel, .vco_level, .group2_invert, .group3_invert,
		.group2_output_a(og[0][0]), .group2_output_b(og[0][1]), .group2_output_c(og[0][2]),
		.group3_output_a(og[1][0]), .group3_output_b(og[1][1]), .group3_output_c(og[1][2]),
		.group2_duty_cycle_correction(dcc[0]), .group3_duty_cycle_correction(dcc[1])
	);

	// 8 ns clock
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// Verdict and end of run
	task results;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results

	// Compare seen with expected
	task chk(input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e)
		begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task tick(input int c);
		repeat (c) @(negedge core_clk);
	endtask : tick

	// One-cycle write strobe; the model follows mapped writes
	task wr(input logic [9:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		tick(1);
		reg_wr_en = 1'b0;
		// Let an edge pass so a following write raises the strobe afresh
		tick(1);
		if (a >= 10'h196 && a <= 10'h19B)
			mdl[a - 10'h196] = d;
	endtask : wr

	// Read and compare; unused channel bits and unmapped places read zero
	task rd(input logic [9:0] a);
		logic [7:0] e;
		e = 8'h00;
		if (a >= 10'h196 && a <= 10'h19B)
			e = 8'(mdl[a - 10'h196]) & ((a == 10'h198 || a == 10'h19B) ? 8'h07 : 8'hFF);
		reg_addr = a;
		reg_rd_en = 1'b1;
		tick(1);
		reg_rd_en = 1'b0;
		tick(1);
		chk(reg_rdata, e);
	endtask : rd

	// Count cycles while output a of group g stays at b, bounded
	task span(input int g, input logic b, output int c);
		c = 0;
		while (og[g][0] === b && c < 99)
		begin
			tick(1);
			c++;
		end
		if (c >= 99)
		begin
			err_total++;
			results();
		end
	endtask : span

	// Measure one whole high run then low run
	task runs(input int g);
		int t;
		span(g, 1'b1, t);
		span(g, 1'b0, t);
		span(g, 1'b1, hi);
		span(g, 1'b0, lo);
	endtask : runs

	initial
	begin
		seed = 32'h2c4a;
		resetn = 1'b0;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 10'h000;
		reg_wdata = 8'h00;
		sync_hold = 1'b0;
		clk_source_sel = 2'h0;
		vco_level = 1'b0;
		group2_invert = 3'h0;
		group3_invert = 3'h0;
		err_total = 0;
		tests_run = 0;
		mdl = '{32'h11, 0, 0, 0, 0, 0};
		tick(4);
		resetn = 1'b1;
		for (v = 10'h195; v <= 10'h19C; v++) rd(10'(v));
		for (v = 0; v < 6; v++) wr(10'h196 + 10'(v), 8'($random(seed)));
		for (v = 10'h195; v <= 10'h19C; v++) rd(10'(v));
		for (v = 0; v < 6; v++) wr(10'h196 + 10'(v), (v == 0) ? 8'h11 : 8'h00);
		$display("test registers done");
		// Default periods
		runs(0);
		chk(8'(lo + hi), 8'h04);
		runs(1);
		chk(8'(lo + hi), 8'h02);
		// Random low and high counts on both groups
		for (n = 0; n < 6; n++)
		begin
			v = $random(seed);
			wr(n[0] ? 10'h199 : 10'h196, 8'(v));
			tick(40);
			runs(n & 1);
			chk(8'(lo), 8'(v[7:4]) + 8'h01);
			chk(8'(hi), 8'(v[3:0]) + 8'h01);
		end
		$display("test periods done");
		// Start level and phase offset after sync release
		for (n = 0; n < 4; n++)
		begin
			v = $random(seed);
			sync_hold = 1'b1;
			wr(10'h199, 8'(v));
			wr(10'h19A, {3'h0, n[0], 4'(v[11:8])});
			tick(3);
			chk({7'h0, og[1][0]}, {7'h0, n[0]});
			sync_hold = 1'b0;
			span(1, n[0], lo);
			chk(8'(lo), 8'(v[11:8]) + 8'(n[0] ? v[3:0] : v[7:4]) + 8'h03);
		end
		$display("test phase done");
		// Masked static levels on all three outputs
		for (n = 0; n < 4; n++)
		begin
			group3_invert = 3'($random(seed));
			sync_hold = n[0];
			wr(10'h19A, {2'b01, n[1:0], 4'h0});
			tick(3);
			chk({5'h0, og[1]}, {5'h0, group3_invert ^ {3{n[1] & n[0]}}});
		end
		// Bypass ignores force and counts, inversion kept
		wr(10'h199, 8'h73);
		wr(10'h19A, 8'hF0);
		tick(4);
		runs(1);
		chk(8'(lo + hi), 8'h02);
		$display("test static done");
		// Direct routing: CLK, no effect, then VCO
		group3_invert = 3'h0;
		sync_hold = 1'b0;
		wr(10'h19A, 8'h00);
		wr(10'h19B, 8'h02);
		for (n = 0; n < 2; n++)
		begin
			clk_source_sel = 2'(n);
			tick(40);
			runs(1);
			chk(8'(lo), (n == 1) ? 8'h08 : 8'h01);
			chk(8'(hi), (n == 1) ? 8'h04 : 8'h01);
		end
		clk_source_sel = 2'h2;
		repeat (8)
		begin
			vco_level = 1'($random(seed));
			tick(6);
			chk({7'h0, og[1][0]}, {7'h0, vco_level});
		end
		$display("test direct done");
		// Power-down beats inversion; correction flags
		group2_invert = 3'h7;
		wr(10'h198, 8'h05);
		wr(10'h19B, 8'h04);
		tick(3);
		chk({2'h0, og[1], og[0]}, 8'h00);
		chk({6'h0, dcc}, 8'h02);
		$display("test power done");
		results();
	end
endmodule : tb_top

`default_nettype wire
